// ===== rcs_board_model.sv
// board side: reset supervisor, strap pins and reset pin pull-up
`timescale 1ns/1ps
`default_nettype none
module rcs_board_model (
    input wire logic clk_in,
    input wire logic hold_in,
    input wire rcs_pkg::rcs_strap_t cfg_in,
    input wire logic pin_low_in,
    input wire logic pin_oe_in,
    input wire logic pin_out_in,
    output logic rst_n_out,
    output rcs_pkg::rcs_strap_t strap_out,
    output logic pin_level_out
);
    initial rst_n_out = 1'b0;
    initial strap_out = '0;
    // straps change only while reset is held
    always @(posedge clk_in)
    begin
        rst_n_out <= !hold_in;
        if (hold_in)
            strap_out <= cfg_in;
    end
    // pin wire: device drive, else board pull-down or pull-up
    assign pin_level_out = pin_oe_in ? pin_out_in : !pin_low_in;
endmodule : rcs_board_model
`default_nettype wire

// ===== rcs_params.svh
// offsets, field positions, reset values and timing counts of the start-up controller
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// register byte offsets
`define RCS_ADDR_PWR 8'h00
`define RCS_ADDR_RRCTL 8'h04
`define RCS_ADDR_STAT 8'h08

// power management control fields
`define RCS_PM_MULT_LSB 0
`define RCS_PM_MULT_W 6
`define RCS_PM_DIV_LSB 8
`define RCS_PM_DIV_W 2
`define RCS_PM_DIV_RST 2'h0

// running reset control fields
`define RCS_RR_PINFN_BIT 0
`define RCS_RR_SOFT_BIT 1

// status fields
`define RCS_ST_BOOT_LSB 0
`define RCS_ST_RATIO_LSB 3
`define RCS_ST_RSVD_BIT 5
`define RCS_ST_OSC_BIT 6
`define RCS_ST_RUN_BIT 7
`define RCS_ST_PINFN_BIT 8

// start-up multipliers for each ratio strap pattern
`define RCS_MULT_8 6'h08
`define RCS_MULT_16 6'h10
`define RCS_MULT_32 6'h20

// pll lock wait in input clock cycles
`define RCS_LOCK_CYCLES 4096

`endif

// ===== rcs_pkg.sv
// types shared by the start-up controller
`default_nettype none
package rcs_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        RCS_HOLD,
        RCS_SAMPLE,
        RCS_LOCK,
        RCS_RUN
    } rcs_state_t;

    // strap levels caught at reset release
    typedef struct packed {
        logic [2:0] boot;
        logic [1:0] ratio;
        logic crystal;
    } rcs_strap_t;

    // pll setting driven to the clock generator
    typedef struct packed {
        logic [5:0] mult;
        logic [1:0] div;
    } rcs_pll_t;

endpackage : rcs_pkg

`default_nettype wire

// ===== rcs_reset_sync.sv
// reset synchroniser: asserts at once, releases on the clock
`timescale 1ns/1ps
`default_nettype none

module rcs_reset_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic rst_n_out
);

    logic meta_q;
    logic sync_q;

    // two-stage release, first stage read only by the second
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign rst_n_out = sync_q;

endmodule : rcs_reset_sync

`default_nettype wire

// ===== rcs_startup.sv
// reset and clock start-up controller with wishbone register access
// Functional notes
// - ratio straps 00 give 8:1, 01 give 32:1, 10 give 16:1; 11 reserved.
// - straps set start-up ratio only; software may rewrite pll settings later.
// - crystal fitted selects internal oscillator, otherwise external clock source.
// - reset input low holds the whole processor in a defined state.
// - after release wait 4096 input clocks, then fetch from reset vector.
// - after reset the reset pin acts as a reset output.
// - bit 0 of running reset control turns the pin into running reset input.
// - boot straps held valid by board, sampled at every reset release.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`include "rcs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rcs_startup #(
    parameter int LOCK_CYCLES = `RCS_LOCK_CYCLES,
    parameter int CNT_W = 13
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [1:0] ratio_strap_in,
    input wire logic [2:0] boot_strap_in,
    input wire logic crystal_fitted_in,
    input wire logic running_reset_input_in,
    output logic reset_output_pin_out,
    output logic reset_pin_oe_out,
    output logic osc_enable_out,
    output logic core_reset_n_out,
    output logic core_start_out,
    output logic [2:0] boot_mode_out,
    output rcs_pkg::rcs_pll_t pll_out,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    logic rst_sync_n;
    rcs_pkg::rcs_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    rcs_pkg::rcs_strap_t strap_q, strap_d;
    rcs_pkg::rcs_pll_t pll_q, pll_d;
    logic rsvd_q, rsvd_d;
    logic pinfn_q, pinfn_d;
    logic start_q, start_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic wr_stb;
    logic soft_rst;
    logic run_rst;

    // ratio strap decode into start-up multiplier
    function automatic logic [5:0] ratio_mult(input logic [1:0] code);
        case (code)
            2'h0: ratio_mult = `RCS_MULT_8;
            2'h1: ratio_mult = `RCS_MULT_32;
            2'h2: ratio_mult = `RCS_MULT_16;
            default: ratio_mult = `RCS_MULT_8; // reserved, safe slowest
        endcase
    endfunction : ratio_mult

    rcs_reset_sync u_rst_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .rst_n_out(rst_sync_n)
    );

    // bus write strobe on the first cycle of a request
    assign wr_stb = ce_in && wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign soft_rst = wr_stb && (wb_adr_i == `RCS_ADDR_RRCTL) && wb_sel_i[0]
        && wb_dat_i[`RCS_RR_SOFT_BIT];
    // pin low restarts the core when in input function
    assign run_rst = pinfn_q && !running_reset_input_in;

    // sequencer and control next values
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        strap_d = strap_q;
        pll_d = pll_q;
        rsvd_d = rsvd_q;
        pinfn_d = pinfn_q;
        start_d = 1'b0;
        case (state_q)
            rcs_pkg::RCS_HOLD:
            begin
                state_d = rcs_pkg::RCS_SAMPLE;
            end
            rcs_pkg::RCS_SAMPLE:
            begin
                strap_d.boot = boot_strap_in;
                strap_d.ratio = ratio_strap_in;
                strap_d.crystal = crystal_fitted_in;
                pll_d.mult = ratio_mult(ratio_strap_in);
                pll_d.div = `RCS_PM_DIV_RST;
                rsvd_d = (ratio_strap_in == 2'h3);
                cnt_d = '0;
                state_d = rcs_pkg::RCS_LOCK;
            end
            rcs_pkg::RCS_LOCK:
            begin
                cnt_d = cnt_q + CNT_W'(1);
                if (cnt_q == CNT_W'(LOCK_CYCLES - 1))
                begin
                    state_d = rcs_pkg::RCS_RUN;
                    start_d = 1'b1;
                end
            end
            rcs_pkg::RCS_RUN:
            begin
                if (wr_stb && wb_adr_i == `RCS_ADDR_PWR)
                begin
                    if (wb_sel_i[0])
                        pll_d.mult = wb_dat_i[`RCS_PM_MULT_LSB +: `RCS_PM_MULT_W];
                    if (wb_sel_i[1])
                        pll_d.div = wb_dat_i[`RCS_PM_DIV_LSB +: `RCS_PM_DIV_W];
                end
            end
            default:
            begin
                state_d = rcs_pkg::RCS_HOLD;
            end
        endcase
        if (wr_stb && wb_adr_i == `RCS_ADDR_RRCTL && wb_sel_i[0])
            pinfn_d = wb_dat_i[`RCS_RR_PINFN_BIT];
        // software or running reset restarts and resamples
        if (soft_rst || run_rst)
            state_d = rcs_pkg::RCS_HOLD;
    end

    always_ff @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_q <= rcs_pkg::RCS_HOLD;
            cnt_q <= '0;
            strap_q <= '0;
            pll_q <= '0;
            rsvd_q <= 1'b0;
            pinfn_q <= 1'b0;
            start_q <= 1'b0;
        end
        else if (ce_in)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            strap_q <= strap_d;
            pll_q <= pll_d;
            rsvd_q <= rsvd_d;
            pinfn_q <= pinfn_d;
            start_q <= start_d;
        end
    end

    // bus answer and read data next values
    always_comb
    begin
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        dat_d = dat_q;
        if (ack_d && !wb_we_i)
        begin
            dat_d = 32'h0000_0000; // unmapped reads return zero
            case (wb_adr_i)
                `RCS_ADDR_PWR:
                begin
                    dat_d[`RCS_PM_MULT_LSB +: `RCS_PM_MULT_W] = pll_q.mult;
                    dat_d[`RCS_PM_DIV_LSB +: `RCS_PM_DIV_W] = pll_q.div;
                end
                `RCS_ADDR_RRCTL:
                begin
                    dat_d[`RCS_RR_PINFN_BIT] = pinfn_q;
                end
                `RCS_ADDR_STAT:
                begin
                    dat_d[`RCS_ST_BOOT_LSB +: 3] = strap_q.boot;
                    dat_d[`RCS_ST_RATIO_LSB +: 2] = strap_q.ratio;
                    dat_d[`RCS_ST_RSVD_BIT] = rsvd_q;
                    dat_d[`RCS_ST_OSC_BIT] = strap_q.crystal;
                    dat_d[`RCS_ST_RUN_BIT] = (state_q == rcs_pkg::RCS_RUN);
                    dat_d[`RCS_ST_PINFN_BIT] = pinfn_q;
                end
                default:
                begin
                    dat_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // bus registers
    always_ff @(posedge clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    // core held until lock wait done
    assign core_reset_n_out = (state_q == rcs_pkg::RCS_RUN);
    assign core_start_out = start_q; // fetch from reset vector
    assign boot_mode_out = strap_q.boot;
    assign osc_enable_out = strap_q.crystal;
    assign pll_out = pll_q;
    // reset output driven unless pin turned to input
    assign reset_pin_oe_out = !pinfn_q;
    assign reset_output_pin_out = core_reset_n_out;

endmodule : rcs_startup

`default_nettype wire

// ===== rcs_startup_properties.sv
// concurrent checks on the start-up controller ports
`timescale 1ns/1ps
`default_nettype none
`include "rcs_params.svh"
module rcs_startup_properties #(
    parameter int LOCK_CYCLES = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic running_reset_input_in,
    input wire logic [1:0] ratio_strap_in,
    input wire logic [2:0] boot_strap_in,
    input wire logic crystal_fitted_in,
    input wire logic ce_in,
    input wire logic reset_output_pin_out,
    input wire logic reset_pin_oe_out,
    input wire logic osc_enable_out,
    input wire logic core_reset_n_out,
    input wire logic core_start_out,
    input wire logic [2:0] boot_mode_out,
    input wire rcs_pkg::rcs_pll_t pll_out,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o
);
    logic [15:0] low_q;
    logic [15:0] low_d;
    // cycles the core has been held since it last ran
    always_comb low_d = core_reset_n_out ? 16'h0000 : low_q + 16'h0001;
    always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in) low_q <= 16'h0000;
        else low_q <= low_d;
    // start-up multiplier per strap pattern, reserved acts as 8
    function automatic logic [5:0] exp_mult(input logic [1:0] r);
        return (r == 2'h1) ? `RCS_MULT_32 : (r == 2'h2) ? `RCS_MULT_16 : `RCS_MULT_8;
    endfunction : exp_mult
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_wb_answer: assert property (ce_in && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_lock_wait: assert property ($rose(core_reset_n_out) |-> low_q >= LOCK_CYCLES + 2)
        else $error("core released before lock wait");
    a_start_pulse: assert property (core_start_out && ce_in |-> core_reset_n_out ##1 !core_start_out)
        else $error("start pulse wrong");
    a_release_quiet: assert property ($rose(rst_n_in) |-> !core_reset_n_out && reset_pin_oe_out)
        else $error("state wrong at reset release");
    a_pin_mirror: assert property (reset_pin_oe_out |-> reset_output_pin_out == core_reset_n_out)
        else $error("reset pin does not follow core reset");
    a_run_reset: assert property (ce_in && !reset_pin_oe_out && !running_reset_input_in
        |=> !core_reset_n_out)
        else $error("running reset ignored");
    a_pin_fn: assert property (wb_ack_o && wb_we_i && wb_adr_i == `RCS_ADDR_RRCTL && wb_sel_i[0]
        |=> reset_pin_oe_out != $past(wb_dat_i[0]))
        else $error("pin function not applied");
    a_start_straps: assert property (core_start_out |-> pll_out.mult == exp_mult(ratio_strap_in)
        && pll_out.div == `RCS_PM_DIV_RST && boot_mode_out == boot_strap_in
        && osc_enable_out == crystal_fitted_in)
        else $error("start-up settings differ from straps");
    c_start: cover property (core_start_out);
    c_run_reset: cover property (!reset_pin_oe_out && !running_reset_input_in);
    c_pin_write: cover property (wb_ack_o && wb_we_i && wb_adr_i == `RCS_ADDR_RRCTL);
endmodule : rcs_startup_properties
bind rcs_startup rcs_startup_properties #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.clk_in, .rst_n_in,
    .running_reset_input_in, .ratio_strap_in, .boot_strap_in, .crystal_fitted_in, .ce_in,
    .reset_output_pin_out, .reset_pin_oe_out, .osc_enable_out, .core_reset_n_out,
    .core_start_out, .boot_mode_out, .pll_out, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o);
`default_nettype wire

// ===== rcs_startup_test.sv
// self-checking bench for the start-up controller
`timescale 1ns/1ps
`default_nettype none
`include "rcs_params.svh"
module rcs_startup_test;
    localparam int LOCK = 8;
    logic clk_in, hold, pin_low, cyc, stb, we, rst_n, pin_lvl, oe, pin_o, osc, core_n, start, ack;
    logic ce;
    logic [7:0] adr;
    logic [31:0] dat, rdat, rd;
    logic [2:0] boot;
    logic [5:0] m;
    rcs_pkg::rcs_strap_t cfg, strap;
    rcs_pkg::rcs_pll_t pll;
    int n_errors = 0;
    int total_checks = 0;
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    rcs_board_model board_u (.clk_in(clk_in), .hold_in(hold), .cfg_in(cfg), .pin_low_in(pin_low),
        .pin_oe_in(oe), .pin_out_in(pin_o), .rst_n_out(rst_n), .strap_out(strap),
        .pin_level_out(pin_lvl));
    rcs_startup #(.LOCK_CYCLES(LOCK), .CNT_W(4)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n),
        .ce_in(ce), .ratio_strap_in(strap.ratio), .boot_strap_in(strap.boot),
        .crystal_fitted_in(strap.crystal), .running_reset_input_in(pin_lvl),
        .reset_output_pin_out(pin_o), .reset_pin_oe_out(oe), .osc_enable_out(osc),
        .core_reset_n_out(core_n), .core_start_out(start), .boot_mode_out(boot), .pll_out(pll),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack));
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // single classic bus cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_in);
        while (ack !== 1'b1 && k < 50)
        begin
            @(posedge clk_in);
            k++;
        end
        if (k == 50) chk(32'h0000_0000, 32'h0000_0001);
        if (k == 50) finish_test();
        rdat = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_in);
    endtask : bus
    // wait for the start pulse and compare start-up settings
    task automatic wait_start();
        int k;
        k = 0;
        while (start !== 1'b1 && k < 100)
        begin
            @(posedge clk_in);
            k++;
        end
        if (k == 100) chk(32'h0000_0000, 32'h0000_0001);
        if (k == 100) finish_test();
        m = (cfg.ratio == 2'h1) ? `RCS_MULT_32 : (cfg.ratio == 2'h2) ? `RCS_MULT_16 : `RCS_MULT_8;
        chk(32'(k > LOCK), 32'h0000_0001);
        chk({20'h0_0000, pll, boot, osc}, {20'h0_0000, m, `RCS_PM_DIV_RST, cfg.boot, cfg.crystal});
    endtask : wait_start
    task automatic restart(input rcs_pkg::rcs_strap_t c);
        @(posedge clk_in);
        hold <= 1'b1;
        cfg <= c;
        repeat (8) @(posedge clk_in);
        hold <= 1'b0;
        wait_start();
    endtask : restart
    // main sequence
    initial
    begin
        hold = 1'b1;
        pin_low = 1'b0;
        ce = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dat = 32'h0000_0000;
        cfg = '0;
        for (int i = 0; i < 4; i++)
        begin
            restart('{boot: 3'(7 - i), ratio: 2'(i), crystal: i[0]});
            bus(1'b0, `RCS_ADDR_STAT, 32'h0000_0000);
            chk(rdat, {23'h00_0000, 2'b01, cfg.crystal, cfg.ratio == 2'h3, cfg.ratio, cfg.boot});
        end
        bus(1'b1, `RCS_ADDR_PWR, 32'h0000_0215);
        bus(1'b0, `RCS_ADDR_PWR, 32'h0000_0000);
        chk(rdat, 32'h0000_0215);
        chk({24'h00_0000, pll}, 32'h0000_0056);
        bus(1'b0, 8'h0C, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        bus(1'b1, `RCS_ADDR_RRCTL, 32'h0000_0001);
        chk({31'h0000_0000, oe}, 32'h0000_0000);
        pin_low <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk({31'h0000_0000, core_n}, 32'h0000_0000);
        pin_low <= 1'b0;
        wait_start();
        bus(1'b1, `RCS_ADDR_RRCTL, 32'h0000_0003);
        wait_start();
        bus(1'b0, `RCS_ADDR_RRCTL, 32'h0000_0000);
        chk(rdat, 32'h0000_0001);
        // soft reset back to output function, lock wait frozen by the enable
        bus(1'b1, `RCS_ADDR_RRCTL, 32'h0000_0002);
        ce <= 1'b0;
        repeat (20) @(posedge clk_in);
        ce <= 1'b1;
        wait_start();
        restart('{boot: 3'h5, ratio: 2'h2, crystal: 1'b1});
        chk({30'h0000_0000, oe, pin_o}, 32'h0000_0003);
        finish_test();
    end
endmodule : rcs_startup_test
`default_nettype wire
